/* File: core/async_serial_receiver.sv */
// Asynchronous serial receiver with Wishbone register access and interrupt.
`timescale 1ns/1ps

// Notes on behaviour
// - Async mode needs port enable, sync clear.
// - Characters accepted only while receive enabled.
// - Buffer load sets receive-complete flag.
// - Interrupt request when flag and enable set.
// - Nine data bits when selected, else eight.
// - Status read gives error flags, ninth bit.
// - Data read gives low eight buffered bits.
// - Overrun stays until receive enable cleared.
// - Nine-bit address mode loads only ninth-bit-one characters.
// - Nine-bit address mode characters report ninth bit one.
// - Address detect off passes every character.
// - Bit rate from divisor pair, speed selects.
module async_serial_receiver (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic ce, // Clock enable, freezes all state when low.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [7:0] wb_adr_i, // Wishbone byte address.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire logic rxPin, // Serial receive line, idle high.
    output logic receiveIrq, // Receive-complete interrupt request.
    output logic irq // Combined enabled event interrupt.
);

    // ==========================================================================
    // State and helpers.
    rx_pkg::rx_regs_t r_q;
    rx_pkg::rx_regs_t r_d;
    logic tick;
    logic portActive;
    logic accepting;
    logic busReq;
    logic busDone;
    logic busWrite;
    logic busRead;
    logic [3:0] lastBit;
    logic [7:0] doneData;
    logic doneNinth;
    localparam int IRQ_W_LOCAL = rx_pkg::IRQ_W;
    logic addrMatch;
    logic [IRQ_W_LOCAL-1:0] events;

    // Register read mux, shared by the data latch of every read.
    function automatic logic [31:0] readMux(input rx_pkg::rx_regs_t s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            rx_pkg::ADDR_CTRL: v[7:0] = s.ctrl;
            rx_pkg::ADDR_DIV_LO: v[7:0] = s.divLo;
            rx_pkg::ADDR_DIV_HI: v[7:0] = s.divHi;
            rx_pkg::ADDR_RX_STATUS: begin
                v[rx_pkg::STAT_NINTH_BIT] = s.rxNinth;
                v[rx_pkg::STAT_OVERRUN_BIT] = s.overrun;
                v[rx_pkg::STAT_FRAME_BIT] = s.rxFrame;
                v[rx_pkg::STAT_FULL_BIT] = s.bufFull;
            end
            rx_pkg::ADDR_RX_DATA: v[7:0] = s.rxData;
            rx_pkg::ADDR_IRQ_STATUS: v[IRQ_W_LOCAL-1:0] = s.irqStat;
            rx_pkg::ADDR_IRQ_ENABLE: v[IRQ_W_LOCAL-1:0] = s.irqEn;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : readMux

    // ==========================================================================
    // Baud generator; it runs only while a character is in flight.
    baud_tick_gen u_baud (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(r_q.state != rx_pkg::ST_IDLE),
        .divisor({r_q.divHi, r_q.divLo}),
        .highSpeed(r_q.ctrl.highSpeedBaudSelect),
        .wide(r_q.ctrl.wideDivisorSelect),
        .tick(tick)
    );

    // ==========================================================================
    // Enables and bus decode.
    // The receiver stops taking characters after an overrun so the held
    // character is not silently replaced; software must toggle receive enable.
    assign portActive = r_q.ctrl.serialPortEnable && !r_q.ctrl.syncModeSelect;
    assign accepting = portActive && r_q.ctrl.continuousReceiveEnable && !r_q.overrun;
    assign busReq = wb_cyc_i && wb_stb_i;
    assign busDone = busReq && r_q.ack;
    assign busWrite = busDone && wb_we_i && wb_sel_i[0];
    assign busRead = busDone && !wb_we_i;

    // ==========================================================================
    // Character assembly: align eight-bit frames and check the address bit.
    always_comb begin
        lastBit = r_q.ctrl.nineBitReceiveSelect ? rx_pkg::BITS_NINE : rx_pkg::BITS_EIGHT;
        if (r_q.ctrl.nineBitReceiveSelect) begin
            doneData = r_q.shift[7:0];
            doneNinth = r_q.shift[8];
        end else begin
            doneData = r_q.shift[8:1];
            doneNinth = 1'b0;
        end
        // With address detect off every character passes.
        addrMatch = !(r_q.ctrl.nineBitReceiveSelect && r_q.ctrl.addressDetectEnable)
                    || doneNinth;
    end

    // ==========================================================================
    // Next-state logic of the whole block.
    always_comb begin
        r_d = r_q;
        events = '0;

        // Pin synchroniser; only the second and third stages feed any logic.
        r_d.rxMeta = rxPin;
        r_d.rxSync = r_q.rxMeta;
        r_d.rxPrev = r_q.rxSync;

        // Bus acknowledge: one wait cycle, then ack for one cycle.
        r_d.ack = busReq && !r_q.ack;
        if (busReq && !r_q.ack) begin
            r_d.rdata = readMux(r_q, wb_adr_i);
        end

        // Register writes take effect at the acknowledged edge.
        if (busWrite) begin
            unique case (wb_adr_i)
                rx_pkg::ADDR_CTRL: r_d.ctrl = rx_pkg::ctrl_t'(wb_dat_i[7:0]);
                rx_pkg::ADDR_DIV_LO: r_d.divLo = wb_dat_i[7:0];
                rx_pkg::ADDR_DIV_HI: r_d.divHi = wb_dat_i[7:0];
                rx_pkg::ADDR_IRQ_ENABLE: r_d.irqEn = wb_dat_i[IRQ_W_LOCAL-1:0];
                rx_pkg::ADDR_IRQ_CLEAR: r_d.irqStat = r_q.irqStat & ~wb_dat_i[IRQ_W_LOCAL-1:0];
                default: r_d.ctrl = r_q.ctrl;
            endcase
        end

        // Reading the data register drains the single-entry buffer.
        if (busRead && wb_adr_i == rx_pkg::ADDR_RX_DATA) begin
            r_d.bufFull = 1'b0;
        end

        // Clearing receive enable is the only way out of overrun.
        if (!r_d.ctrl.continuousReceiveEnable) begin
            r_d.overrun = 1'b0;
        end

        // Receive state machine, advanced on baud ticks.
        unique case (r_q.state)
            rx_pkg::ST_IDLE: begin
                r_d.sub = 2'h0;
                r_d.bitCnt = 4'h0;
                if (accepting && r_q.rxPrev && !r_q.rxSync) begin
                    r_d.state = rx_pkg::ST_START;
                end
            end
            rx_pkg::ST_START: begin
                if (tick) begin
                    r_d.sub = r_q.sub + 2'h1;
                    if (r_q.sub == rx_pkg::TICK_HALF) begin
                        // A start bit gone high by mid-bit was a glitch.
                        r_d.sub = 2'h0;
                        r_d.state = r_q.rxSync ? rx_pkg::ST_IDLE : rx_pkg::ST_DATA;
                    end
                end
            end
            rx_pkg::ST_DATA: begin
                if (tick) begin
                    r_d.sub = r_q.sub + 2'h1;
                    if (r_q.sub == rx_pkg::TICK_LAST) begin
                        r_d.shift = {r_q.rxSync, r_q.shift[8:1]};
                        r_d.bitCnt = r_q.bitCnt + 4'h1;
                        if (r_q.bitCnt + 4'h1 == lastBit) begin
                            r_d.state = rx_pkg::ST_STOP;
                        end
                    end
                end
            end
            rx_pkg::ST_STOP: begin
                if (tick) begin
                    r_d.sub = r_q.sub + 2'h1;
                    if (r_q.sub == rx_pkg::TICK_LAST) begin
                        r_d.state = rx_pkg::ST_IDLE;
                        if (addrMatch && r_d.ctrl.continuousReceiveEnable) begin
                            if (r_q.bufFull && r_d.bufFull) begin
                                // Held character is kept; the new one is lost.
                                r_d.overrun = 1'b1;
                                events[rx_pkg::IRQ_OVER_BIT] = 1'b1;
                            end else begin
                                r_d.rxData = doneData;
                                r_d.rxNinth = doneNinth;
                                r_d.rxFrame = !r_q.rxSync;
                                r_d.bufFull = 1'b1;
                                events[rx_pkg::IRQ_DONE_BIT] = 1'b1;
                                events[rx_pkg::IRQ_FRAME_BIT] = !r_q.rxSync;
                            end
                        end
                    end
                end
            end
        endcase

        // Losing the enables aborts a character in flight.
        if (!accepting && r_q.state != rx_pkg::ST_IDLE && !r_q.overrun) begin
            r_d.state = rx_pkg::ST_IDLE;
        end else if (!portActive || !r_d.ctrl.continuousReceiveEnable) begin
            r_d.state = rx_pkg::ST_IDLE;
        end

        // Sticky events: a new event wins over a clear in the same cycle.
        r_d.irqStat = r_d.irqStat | events;
    end

    // ==========================================================================
    // Single state register; the pin stages reset to idle-high.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.rxMeta <= 1'b1;
            r_q.rxSync <= 1'b1;
            r_q.rxPrev <= 1'b1;
            r_q.state <= rx_pkg::ST_IDLE;
            r_q.ctrl <= rx_pkg::ctrl_t'(rx_pkg::CTRL_RESET);
            r_q.divLo <= rx_pkg::DIV_RESET;
            r_q.divHi <= rx_pkg::DIV_RESET;
            r_q.irqStat <= rx_pkg::IRQ_RESET;
            r_q.irqEn <= rx_pkg::IRQ_RESET;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    // ==========================================================================
    // Outputs.
    // The receive-complete flag is the buffer-full state: set on load,
    // cleared when software drains the data register.
    assign wb_dat_o = r_q.rdata;
    assign wb_ack_o = r_q.ack;
    assign receiveIrq = r_q.bufFull && r_q.ctrl.receiveInterruptEnable;
    assign irq = |(r_q.irqStat & r_q.irqEn);

endmodule : async_serial_receiver

/* File: core/baud_tick_gen.sv */
// Baud tick generator: four ticks per bit from divisor and speed selects.
`timescale 1ns/1ps
module baud_tick_gen (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic ce, // Clock enable, freezes state when low.
    input wire logic run, // Counting allowed; low holds the phase at zero.
    input wire logic [15:0] divisor, // Divisor pair, high byte above low byte.
    input wire logic highSpeed, // High speed select.
    input wire logic wide, // Sixteen-bit divisor select.
    output logic tick // One-cycle quarter-bit pulse.
);

    // ==========================================================================
    // Speed decode.
    rx_pkg::baud_regs_t r_q;
    rx_pkg::baud_regs_t r_d;
    logic [3:0] preLast;
    logic [15:0] divLast;

    // Quarter-bit prescale per mode; eight-bit mode ignores the high byte.
    always_comb begin
        if (wide) begin
            preLast = highSpeed ? rx_pkg::PRE_FAST : rx_pkg::PRE_MID;
            divLast = divisor;
        end else begin
            preLast = highSpeed ? rx_pkg::PRE_MID : rx_pkg::PRE_SLOW;
            divLast = {8'h00, divisor[7:0]};
        end
    end

    // ==========================================================================
    // Two cascaded counters; holding them at zero while idle aligns the
    // phase to the start edge, so mid-bit sampling needs no oversampling.
    always_comb begin
        r_d = r_q;
        r_d.tick = 1'b0;
        if (!run) begin
            r_d.pre = 4'h0;
            r_d.cnt = 16'h0000;
        end else if (r_q.pre != preLast) begin
            r_d.pre = r_q.pre + 4'h1;
        end else begin
            r_d.pre = 4'h0;
            if (r_q.cnt >= divLast) begin
                r_d.cnt = 16'h0000;
                r_d.tick = 1'b1;
            end else begin
                r_d.cnt = r_q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    assign tick = r_q.tick;

endmodule : baud_tick_gen

/* File: shared/rx_pkg.sv */
// Shared constants, register map and carrier types of the asynchronous serial receiver.
package rx_pkg;

    // ==========================================================================
    // Register byte offsets on the Wishbone slave (32-bit words, data in low byte).
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIV_LO = 8'h04;
    localparam logic [7:0] ADDR_DIV_HI = 8'h08;
    localparam logic [7:0] ADDR_RX_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_RX_DATA = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1c;

    // ==========================================================================
    // Receive status register bit positions.
    localparam int STAT_NINTH_BIT = 0;
    localparam int STAT_OVERRUN_BIT = 1;
    localparam int STAT_FRAME_BIT = 2;
    localparam int STAT_FULL_BIT = 3;

    // Interrupt status, enable and clear share this layout.
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FRAME_BIT = 1;
    localparam int IRQ_OVER_BIT = 2;

    // ==========================================================================
    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // ==========================================================================
    // Timing: the baud generator ticks four times per bit.
    // Prescale values are the clock count per divisor step, minus one.
    localparam int CLK_HZ = 25000000;
    localparam logic [3:0] PRE_SLOW = 4'hf;
    localparam logic [3:0] PRE_MID = 4'h3;
    localparam logic [3:0] PRE_FAST = 4'h0;
    localparam logic [1:0] TICK_LAST = 2'h3;
    localparam logic [1:0] TICK_HALF = 2'h1;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;

    // ==========================================================================
    // Control register: MSB first, bit 7 down to bit 0.
    typedef struct packed {
        logic receiveInterruptEnable;
        logic wideDivisorSelect;
        logic highSpeedBaudSelect;
        logic addressDetectEnable;
        logic nineBitReceiveSelect;
        logic continuousReceiveEnable;
        logic syncModeSelect;
        logic serialPortEnable;
    } ctrl_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } rx_state_t;

    // Whole state of the receiver top.
    typedef struct packed {
        logic rxMeta;
        logic rxSync;
        logic rxPrev;
        rx_state_t state;
        logic [1:0] sub;
        logic [3:0] bitCnt;
        logic [8:0] shift;
        ctrl_t ctrl;
        logic [7:0] divLo;
        logic [7:0] divHi;
        logic [7:0] rxData;
        logic rxNinth;
        logic rxFrame;
        logic bufFull;
        logic overrun;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqEn;
        logic ack;
        logic [31:0] rdata;
    } rx_regs_t;

    // Whole state of the baud tick generator.
    typedef struct packed {
        logic [3:0] pre;
        logic [15:0] cnt;
        logic tick;
    } baud_regs_t;

endpackage : rx_pkg

/* File: verif/async_serial_receiver_assertions.sv */
// Port-level checker for the asynchronous serial receiver.
`timescale 1ns/1ps
module async_serial_receiver_checker (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic wb_cyc_i, // Cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic wb_we_i, // Write.
    input wire logic [7:0] wb_adr_i, // Address.
    input wire logic [3:0] wb_sel_i, // Selects.
    input wire logic [31:0] wb_dat_i, // Write data.
    input wire logic [31:0] wb_dat_o, // Read data.
    input wire logic wb_ack_o, // Acknowledge.
    input wire logic rxPin, // Serial line.
    input wire logic receiveIrq, // Receive request.
    input wire logic irq // Combined request.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Read decodes, so each property names what it watches.
    logic rdReq, rdData, rdStat, rdIrq;
    assign rdReq = wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
    assign rdData = rdReq && wb_adr_i == rx_pkg::ADDR_RX_DATA;
    assign rdStat = rdReq && wb_adr_i == rx_pkg::ADDR_RX_STATUS;
    assign rdIrq = rdReq && wb_adr_i == rx_pkg::ADDR_IRQ_STATUS;

    property p_ackAfterReq;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ackAfterReq: assert property (p_ackAfterReq) else $error("ack late");
    property p_ackOne;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack too long");
    property p_popClears;
        rdData |=> !receiveIrq;
    endproperty
    a_popClears: assert property (p_popClears) else $error("pop kept flag");
    property p_statusIrq;
        rdStat && !wb_dat_o[rx_pkg::STAT_FULL_BIT] |-> !$past(receiveIrq);
    endproperty
    a_statusIrq: assert property (p_statusIrq) else $error("irq without char");
    property p_irqZero;
        rdIrq && wb_dat_o[2:0] == 3'h0 |-> !$past(irq);
    endproperty
    a_irqZero: assert property (p_irqZero) else $error("irq without event");
    property p_dataWidth;
        rdData |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_dataWidth: assert property (p_dataWidth) else $error("data too wide");
    property p_statWidth;
        rdStat |-> wb_dat_o[31:4] == 28'h0;
    endproperty
    a_statWidth: assert property (p_statWidth) else $error("status too wide");
    property p_irqFall;
        $fell(irq) |-> $past(wb_ack_o) && $past(wb_we_i);
    endproperty
    a_irqFall: assert property (p_irqFall) else $error("irq fell alone");
    property p_rxIrqFall;
        $fell(receiveIrq) |-> $past(wb_ack_o);
    endproperty
    a_rxIrqFall: assert property (p_rxIrqFall) else $error("flag fell alone");

    c_pop: cover property (rdData);
    c_irq: cover property ($rose(irq));
    c_rxIrq: cover property ($rose(receiveIrq));
endmodule : async_serial_receiver_checker

bind async_serial_receiver async_serial_receiver_checker checker_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxPin(rxPin), .receiveIrq(receiveIrq),
    .irq(irq)
);

/* File: verif/serial_tx_model.sv */
// Behavioural remote serial transmitter that drives the receive line.
`timescale 1ns/1ps
module serial_tx_model (
    input wire logic clk, // System clock.
    input wire logic go, // Starts one frame.
    input wire logic [8:0] dataBits, // Character to send.
    input wire logic nine, // Nine data bits when high.
    input wire logic stopLevel, // Low sends a broken stop bit.
    input wire logic [7:0] bitClks, // Clocks per bit, slow or prompt.
    output logic line, // Serial line, idles high.
    output logic busy // High while a frame is on the line.
);
    logic [10:0] frame;

    // ==========================================================
    // Frame sender: start low, data LSB first, then the stop bit.
    initial begin
        // The line is a plain digital level from the start, never analog.
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                if (nine) begin
                    frame = {stopLevel, dataBits, 1'b0};
                end else begin
                    frame = {1'b1, stopLevel, dataBits[7:0], 1'b0};
                end
                busy <= 1'b1;
                for (int i = 0; i < (nine ? 11 : 10); i++) begin
                    line <= frame[i];
                    repeat (bitClks) @(posedge clk);
                end
                // The line returns to its idle mark level between frames.
                line <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule : serial_tx_model

/* File: verif/test_async_serial_receiver.sv */
// Self-checking testbench of the asynchronous serial receiver.
`timescale 1ns/1ps
module test_async_serial_receiver;
    localparam int LIMIT = 20000;
    logic clk = 1'b0, rst_n = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [7:0] wbAdr = 8'h00, bitLen = 8'h10;
    logic [3:0] wbSel = 4'hf;
    logic [31:0] wbDatW = 32'h0, wbDatR, rdVal;
    logic rxLine, receiveIrq, irq, txGo = 1'b0, txNine = 1'b0, txStop = 1'b1, txBusy;
    logic [8:0] txData = 9'h0;
    int fails = 0, cmpCount = 0, cycles = 0;
    logic [7:0] rateCtrl[4] = '{8'he5, 8'ha5, 8'hc5, 8'h85};
    logic [7:0] rateDiv[4] = '{8'h03, 8'h01, 8'h02, 8'h00};
    logic [7:0] rateLen[4] = '{8'h10, 8'h20, 8'h30, 8'h40};
    logic [7:0] offCtrl[3] = '{8'he4, 8'he7, 8'he1};
    logic [7:0] resetAdr[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h20};

    async_serial_receiver DUT (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .rxPin(rxLine), .receiveIrq(receiveIrq), .irq(irq)
    );
    serial_tx_model tx (
        .clk(clk), .go(txGo), .dataBits(txData), .nine(txNine), .stopLevel(txStop),
        .bitClks(bitLen), .line(rxLine), .busy(txBusy)
    );

    // ==========================================================
    // Clock and hang guard.
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            conclude();
        end
    end

    // ==========================================================
    // Bus, line and comparison tasks.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One classic cycle; the request holds until ack is sampled high.
    task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        do @(posedge clk); while (wbAck !== 1'b1);
        rdVal = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wbXfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wbXfer(1'b1, a, d);
        @(posedge clk);
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wbXfer(1'b0, a, 32'h0);
        chk(what, exp, rdVal);
    endtask : rdChk
    // Sends one frame and leaves one idle bit for the buffer load.
    task automatic sendChar(input logic [8:0] d, input logic nine, input logic stop);
        @(posedge clk);
        txData <= d;
        txNine <= nine;
        txStop <= stop;
        txGo <= 1'b1;
        @(posedge clk);
        txGo <= 1'b0;
        @(posedge clk);
        while (txBusy !== 1'b0) @(posedge clk);
        repeat (bitLen) @(posedge clk);
    endtask : sendChar
    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (resetAdr[i]) rdChk(resetAdr[i], 32'h0, "reset");
        wr(8'h20, 32'h55);
        rdChk(8'h20, 32'h0, "unmapped");
        wr(rx_pkg::ADDR_IRQ_ENABLE, 32'h7);
        // Each speed select pairing at its own bit length.
        foreach (rateCtrl[i]) begin
            wr(rx_pkg::ADDR_DIV_LO, {24'h0, rateDiv[i]});
            wr(rx_pkg::ADDR_CTRL, {24'h0, rateCtrl[i]});
            bitLen <= rateLen[i];
            sendChar({1'b0, 8'ha5 ^ rateDiv[i]}, 1'b0, 1'b1);
            chk("rxIrq", 32'h1, {31'h0, receiveIrq});
            rdChk(rx_pkg::ADDR_RX_STATUS, 32'h8, "status");
            rdChk(rx_pkg::ADDR_RX_DATA, {24'h0, 8'ha5 ^ rateDiv[i]}, "data");
            rdChk(rx_pkg::ADDR_RX_STATUS, 32'h0, "empty");
        end
        wr(rx_pkg::ADDR_DIV_LO, 32'h3);
        bitLen <= 8'h10;
        // Port off, synchronous select, receive off: nothing arrives.
        foreach (offCtrl[i]) begin
            wr(rx_pkg::ADDR_CTRL, {24'h0, offCtrl[i]});
            sendChar(9'h03c, 1'b0, 1'b1);
            rdChk(rx_pkg::ADDR_RX_STATUS, 32'h0, "off");
        end
        wr(rx_pkg::ADDR_CTRL, 32'hed);
        sendChar(9'h13c, 1'b1, 1'b1);
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'h9, "ninth");
        rdChk(rx_pkg::ADDR_RX_DATA, 32'h3c, "data9");
        wr(rx_pkg::ADDR_CTRL, 32'hfd);
        sendChar(9'h055, 1'b1, 1'b1);
        // A dropped character leaves the ninth bit of the last loaded one readable.
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'h1, "dropped");
        sendChar(9'h1aa, 1'b1, 1'b1);
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'h9, "address");
        rdChk(rx_pkg::ADDR_RX_DATA, 32'haa, "addrData");
        wr(rx_pkg::ADDR_CTRL, 32'h6d);
        sendChar(9'h044, 1'b1, 1'b1);
        chk("rxIrqOff", 32'h0, {31'h0, receiveIrq});
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'h8, "allPass");
        rdChk(rx_pkg::ADDR_RX_DATA, 32'h44, "passData");
        // Broken stop bit, then masking and clearing of the events.
        wr(rx_pkg::ADDR_CTRL, 32'he5);
        wr(rx_pkg::ADDR_IRQ_CLEAR, 32'h7);
        sendChar(9'h05a, 1'b0, 1'b0);
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'hc, "frame");
        rdChk(rx_pkg::ADDR_IRQ_STATUS, 32'h3, "irqStat");
        rdChk(rx_pkg::ADDR_RX_DATA, 32'h5a, "frameData");
        wr(rx_pkg::ADDR_IRQ_ENABLE, 32'h0);
        chk("irqMask", 32'h0, {31'h0, irq});
        wbSel <= 4'he;
        wr(rx_pkg::ADDR_IRQ_ENABLE, 32'h2);
        wbSel <= 4'hf;
        rdChk(rx_pkg::ADDR_IRQ_ENABLE, 32'h0, "selOff");
        wr(rx_pkg::ADDR_IRQ_ENABLE, 32'h2);
        chk("irqOn", 32'h1, {31'h0, irq});
        wr(rx_pkg::ADDR_IRQ_CLEAR, 32'h2);
        chk("irqClr", 32'h0, {31'h0, irq});
        rdChk(rx_pkg::ADDR_IRQ_STATUS, 32'h1, "irqLeft");
        wr(rx_pkg::ADDR_IRQ_CLEAR, 32'h7);
        // Overrun: a second character while the buffer is full, then a third while overrun holds.
        sendChar(9'h011, 1'b0, 1'b1);
        sendChar(9'h022, 1'b0, 1'b1);
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'ha, "overrun");
        rdChk(rx_pkg::ADDR_IRQ_STATUS, 32'h5, "overIrq");
        rdChk(rx_pkg::ADDR_RX_DATA, 32'h11, "oldest");
        sendChar(9'h033, 1'b0, 1'b1);
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'h2, "halted");
        wr(rx_pkg::ADDR_CTRL, 32'he1);
        rdChk(rx_pkg::ADDR_RX_STATUS, 32'h0, "recover");
        wr(rx_pkg::ADDR_CTRL, 32'he5);
        sendChar(9'h066, 1'b0, 1'b1);
        rdChk(rx_pkg::ADDR_RX_DATA, 32'h66, "again");
        conclude();
    end
endmodule : test_async_serial_receiver
